/* bench/ibb_indicator_ctrl_chk.sv */
// checker: register echo, pin muxing and blink timing of the indicator block
// assumes it is bound to ibb_indicator_ctrl and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module ibb_chk
    import ibb_pkg::*;
#(
    parameter int HALF_STEP_CYC = 4
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [1:0] gpio_out_data,
    input wire logic [1:0] gpio_dir,
    input wire logic [1:0] gpio_in_data,
    input wire logic [1:0] gpio_in_valid,
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe
);
    // ------------------------------------------------------------
    // shadow registers and blink segment timer
    // ------------------------------------------------------------
    logic [7:0] cfg_q [4]; // config bytes, offset minus 0x0806
    logic hit; // one of the four mapped bytes
    logic [7:0] rd_exp; // byte a read should return
    logic prev_q; // pin0 level at the last edge
    logic seg_ok_q; // level began with no write since, so it is timeable
    logic [15:0] len_q; // cycles spent at the current level
    logic [15:0] half_len; // rate 0 acts as one step
    assign hit = reg_addr >= IBB_IND0_PATTERN_OFS && reg_addr <= IBB_IND1_RUN_OFS;
    assign rd_exp = cfg_q[reg_addr[1:0] - 2'h2];
    assign half_len = (cfg_q[0][5:0] == 6'h00 ? 16'h1 : 16'(cfg_q[0][5:0])) * 16'(HALF_STEP_CYC);
    // a write may retime the pattern, so it voids the segment under way
    always_ff @(posedge mclk) begin
        if (srst) begin
            cfg_q <= '{default: 8'h00};
            seg_ok_q <= 1'b0;
        end else begin
            if (reg_wr && hit) begin
                cfg_q[reg_addr[1:0] - 2'h2] <= reg_wdata;
            end
            seg_ok_q <= reg_wr ? 1'b0 : (pin_out[0] != prev_q) | seg_ok_q;
        end
        prev_q <= pin_out[0];
        len_q <= (pin_out[0] != prev_q) ? 16'h1 : len_q + 16'h1;
    end
    reset_out_a: assert property (@(posedge mclk)
        srst |=> pin_oe == 2'b00 && reg_rdata == 8'h00 && gpio_in_valid == 2'b11)
        else $error("outputs not cleared by reset");
    rd_echo_a: assert property (@(posedge mclk) disable iff (srst)
        reg_rd && hit |=> reg_rdata == $past(rd_exp)) else $error("read data differs from write");
    unmapped_rd_a: assert property (@(posedge mclk) disable iff (srst)
        reg_rd && !hit |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    gp_pass_a: assert property (@(posedge mclk) disable iff (srst)
        !$past(srst) && !$past(cfg_q[1][0]) |-> pin_out[0] == $past(gpio_out_data[0])
        && pin_oe[0] == $past(gpio_dir[0])) else $error("general pin not passed through");
    ind_oe_a: assert property (@(posedge mclk) disable iff (srst)
        !$past(srst) |-> (!$past(cfg_q[1][0]) || pin_oe[0]) && (!$past(cfg_q[3][0]) || pin_oe[1]))
        else $error("indicator pin not driven");
    gpin_valid_a: assert property (@(posedge mclk) disable iff (srst)
        !$past(srst) |-> gpio_in_valid == ~{$past(cfg_q[3][0]), $past(cfg_q[1][0])}
        && (gpio_in_data & ~gpio_in_valid) == 2'b00) else $error("input valid flag wrong");
    blink_half_a: assert property (@(posedge mclk) disable iff (srst)
        seg_ok_q && pin_out[0] != prev_q && cfg_q[1][0] && !cfg_q[0][6] |-> len_q == half_len)
        else $error("blink half period has wrong length");
    breathe_stop_a: assert property (@(posedge mclk) disable iff (srst)
        reg_wr && reg_addr == IBB_IND0_RUN_OFS && reg_wdata[1:0] == 2'b01
        && cfg_q[1][1:0] == 2'b11 && cfg_q[0][6] |-> ##4 (pin_out[0] == cfg_q[0][7]) [*8])
        else $error("breathe did not stop at once");
endmodule // ibb_chk
`default_nettype wire

/* bench/ibb_led_model.sv */
// load on the two indicator pins: loops a driven level back and counts edges
// assumes the bench drives ext_en and ext_val only while a pin is released
`timescale 1ns/1ps
`default_nettype none
module ibb_led_model (
    input wire logic mclk,
    input wire logic clr,
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe,
    input wire logic [1:0] ext_en,
    input wire logic [1:0] ext_val,
    output logic [1:0] pin_in,
    output logic [7:0] chg_cnt
);
    // ------------------------------------------------------------
    // wire level and edge counter
    // ------------------------------------------------------------
    logic [1:0] last_q; // pin level at the last edge
    logic [1:0] float_q = 2'b01; // an undriven pin wanders, never holds
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & float_q);
    // every level change of either pin counts as one edge
    always @(posedge mclk) begin
        float_q <= ~float_q;
        last_q <= pin_out;
        chg_cnt <= clr ? 8'h00 : chg_cnt + 8'(pin_out[0] ^ last_q[0]) + 8'(pin_out[1] ^ last_q[1]);
    end
endmodule // ibb_led_model
`default_nettype wire

/* bench/tb_indicator_blink_breathe_ctrl.sv */
// bench top: register traffic, general pins, blink trail and breathe stop
// assumes the package, the design, the checker and the load model come first
`timescale 1ns/1ps
`default_nettype none
module tb_indicator_blink_breathe_ctrl;
    import ibb_pkg::*;
    // ------------------------------------------------------------
    // clock, design, load and result monitor
    // ------------------------------------------------------------
    localparam int HALF_STEP_CYC = 4; // short half step keeps the run brief
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata, chg_cnt;
    logic [1:0] gpio_out_data = 2'b00, gpio_dir = 2'b00, ext_en = 2'b11, ext_val = 2'b00;
    logic [1:0] gpio_in_data, gpio_in_valid, pin_in, pin_out, pin_oe, pol_now;
    logic clr = 1'b1, smp = 1'b0, rd_d = 1'b0;
    logic [15:0] exp_q [$]; // expected results, oldest first
    int bad_count = 0, n_checks = 0, seed = 32'h79A059AC;
    always #5 mclk = ~mclk;
    ibb_indicator_ctrl #(.HALF_STEP_CYC(HALF_STEP_CYC)) u_dut (
        .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpio_out_data(gpio_out_data),
        .gpio_dir(gpio_dir), .gpio_in_data(gpio_in_data), .gpio_in_valid(gpio_in_valid),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
    ibb_led_model u_load (.mclk(mclk), .clr(clr), .pin_out(pin_out), .pin_oe(pin_oe),
        .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in), .chg_cnt(chg_cnt));
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        n_checks++;
        if (seen !== want) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // strobes last one cycle; a write takes effect at its edge
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_rd = 1'b1;
        exp_q.push_back({8'h00, d});
        @(negedge mclk);
        reg_rd = 1'b0;
    endtask
    task automatic look(input logic [15:0] e);
        @(negedge mclk);
        exp_q.push_back(e);
        smp = 1'b1;
        @(negedge mclk);
        smp = 1'b0;
    endtask
    // read data shows one cycle after the strobe, pins are sampled when asked
    always @(posedge mclk) begin
        rd_d <= reg_rd;
        if (rd_d) check({8'h00, reg_rdata}, exp_q.pop_front());
        if (smp) check({chg_cnt, pin_oe, pin_out, gpio_in_valid, gpio_in_data}, exp_q.pop_front());
    end
    initial begin
        logic [7:0] v [4];
        int i, k, ch, p;
        logic [15:0] base;
        repeat (16) @(negedge mclk);
        srst = 1'b0;
        for (i = 0; i < 4; i++) rd(IBB_IND0_PATTERN_OFS + 16'(i), IBB_CFG_RESET);
        look({8'h00, 2'b00, 2'b00, 2'b11, 2'b00});
        // random bytes, run bits kept clear so no engine starts
        for (i = 0; i < 4; i++) v[i] = 8'($random(seed)) & (i[0] ? 8'hFD : 8'hFF);
        for (i = 0; i < 4; i++) wr(IBB_IND0_PATTERN_OFS + 16'(i), v[i]);
        wr(16'h080A, 8'hFF);
        for (i = 0; i < 4; i++) rd(IBB_IND0_PATTERN_OFS + 16'(i), v[i]);
        rd(16'h080A, 8'h00);
        rd(16'h0805, 8'h00);
        wr(IBB_IND0_RUN_OFS, 8'h00);
        wr(IBB_IND1_RUN_OFS, 8'h00);
        // general function: odd passes drive and loop back, even passes read the load
        for (i = 0; i < 8; i++) begin
            gpio_dir = i[0] ? 2'b11 : 2'b00;
            ext_en = ~gpio_dir;
            gpio_out_data = 2'($random(seed));
            ext_val = 2'($random(seed));
            repeat (4) @(negedge mclk);
            look({8'h00, gpio_dir, gpio_out_data, 2'b11, (i[0] ? gpio_out_data : ext_val)});
        end
        ext_en = 2'b00;
        wr(IBB_IND0_RUN_OFS, 8'h01);
        wr(IBB_IND1_RUN_OFS, 8'h01);
        pol_now = {v[2][7], 1'b0}; // pin1 keeps its random polarity until rewritten
        // blink rate 2, start then stop at once; trail 3 buys one more period
        for (k = 0; k < 8; k++) begin
            ch = k[2];
            p = k[1];
            base = IBB_IND0_PATTERN_OFS + 16'(2 * ch);
            wr(base, {p[0], 7'h02});
            pol_now[ch] = p[0];
            clr = 1'b1;
            repeat (3) @(negedge mclk);
            clr = 1'b0;
            wr(base + 16'h1, {(k[0] ? 6'h03 : 6'h00), 2'b11});
            wr(base + 16'h1, {(k[0] ? 6'h03 : 6'h00), 2'b01});
            repeat (150) @(negedge mclk);
            look({(k[0] ? 8'h04 : 8'h02), 2'b11, pol_now, 4'h0});
        end
        // breathe rate 1 on pin0, stopped in mid breath
        wr(IBB_IND0_PATTERN_OFS, 8'h41);
        wr(IBB_IND0_RUN_OFS, 8'h03);
        repeat (40) @(negedge mclk);
        wr(IBB_IND0_RUN_OFS, 8'h01);
        pol_now[0] = 1'b0;
        clr = 1'b1;
        repeat (3) @(negedge mclk);
        clr = 1'b0;
        repeat (100) @(negedge mclk);
        look({8'h00, 2'b11, pol_now, 4'h0});
        // breathe rate 1 with one sleep step on pin1: 80 cycles lit, 80 dark
        wr(IBB_IND1_PATTERN_OFS, 8'h41);
        wr(IBB_IND1_RUN_OFS, 8'h07);
        repeat (88) @(negedge mclk);
        clr = 1'b1;
        repeat (3) @(negedge mclk);
        clr = 1'b0;
        repeat (50) @(negedge mclk);
        look({8'h00, 2'b11, 2'b00, 4'h0});
        give_verdict();
    end
    // the whole sequence needs about 1700 cycles
    initial begin
        repeat (6000) @(posedge mclk);
        bad_count++;
        give_verdict();
    end
endmodule // tb_indicator_blink_breathe_ctrl
bind ibb_indicator_ctrl ibb_chk #(.HALF_STEP_CYC(HALF_STEP_CYC)) u_chk (
    .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpio_out_data(gpio_out_data), .gpio_dir(gpio_dir),
    .gpio_in_data(gpio_in_data), .gpio_in_valid(gpio_in_valid), .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire

/* verilog/ibb_indicator_ctrl.sv */
// two indicator pin controllers with byte registers, blink and breathe engines
// assumes the register port is synchronous to mclk; pins come from outside
`timescale 1ns/1ps
`default_nettype none

module ibb_indicator_ctrl
    import ibb_pkg::*;
#(
    parameter int HALF_STEP_CYC = IBB_HALF_STEP_CYC // shorten for simulation
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [1:0] gpio_out_data,
    input wire logic [1:0] gpio_dir,
    output logic [1:0] gpio_in_data,
    output logic [1:0] gpio_in_valid,
    input wire logic [1:0] pin_in,
    output logic [1:0] pin_out,
    output logic [1:0] pin_oe
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0][7:0] pat; // pattern cfg per channel
        logic [1:0][7:0] run; // run cfg per channel
        logic [7:0] rdata; // read data
        logic [1:0] gval; // general input valid, lines up with gpin
        logic [7:0] pwm; // shared pwm ramp
        ibb_ch_s [1:0] ch; // per-channel engine
    } ibb_top_s;

    ibb_top_s s_q;
    ibb_top_s s_d;

    // a zero rate would give a zero-length period; treat it as one step
    function automatic logic [5:0] ibb_min1(input logic [5:0] v);
        return (v == 6'h00) ? 6'h01 : v;
    endfunction

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [5:0] rate;
        logic [5:0] tr;
        logic tick;
        logic ind;
        logic runb;
        logic patv;
        logic [11:0] breath_len;
        logic [11:0] sleep_len;
        rate = 6'h00;
        tr = 6'h00;
        tick = 1'b0;
        ind = 1'b0;
        runb = 1'b0;
        patv = 1'b0;
        breath_len = 12'h000;
        sleep_len = 12'h000;
        s_d = s_q;
        s_d.pwm = s_q.pwm + 8'h01;

        // register writes; each of the four bytes has its own address compare
        if (reg_wr && reg_addr == IBB_IND0_PATTERN_OFS) begin
            s_d.pat[0] = reg_wdata;
        end else if (reg_wr && reg_addr == IBB_IND0_RUN_OFS) begin
            s_d.run[0] = reg_wdata;
        end else if (reg_wr && reg_addr == IBB_IND1_PATTERN_OFS) begin
            s_d.pat[1] = reg_wdata; // [R10]
        end else if (reg_wr && reg_addr == IBB_IND1_RUN_OFS) begin
            s_d.run[1] = reg_wdata; // [R10]
        end

        // register reads; unmapped addresses read as zero
        if (reg_rd) begin
            if (reg_addr == IBB_IND0_PATTERN_OFS) begin
                s_d.rdata = s_q.pat[0];
            end else if (reg_addr == IBB_IND0_RUN_OFS) begin
                s_d.rdata = s_q.run[0];
            end else if (reg_addr == IBB_IND1_PATTERN_OFS) begin
                s_d.rdata = s_q.pat[1];
            end else if (reg_addr == IBB_IND1_RUN_OFS) begin
                s_d.rdata = s_q.run[1];
            end else begin
                s_d.rdata = 8'h00;
            end
        end

        // per-channel engines, both identical
        for (int i = 0; i < 2; i++) begin
            rate = ibb_min1(s_q.pat[i][IBB_RATE_MSB:0]);
            tr = s_q.run[i][7:IBB_TRAIL_LSB];
            ind = s_q.run[i][IBB_FUNC_BIT];
            runb = s_q.run[i][IBB_RUN_BIT];
            breath_len = 12'(rate * IBB_HALVES_PER_BREATHE); // [R3]
            sleep_len = 12'(tr * IBB_HALVES_PER_BREATHE); // [R5]
            s_d.ch[i].pin_sync = {s_q.ch[i].pin_sync[0], pin_in[i]};

            // half-step prescaler runs only while a pattern is active
            tick = (s_q.ch[i].pre == 32'(HALF_STEP_CYC - 1));
            s_d.ch[i].pre = tick ? 32'h00000000 : s_q.ch[i].pre + 32'h00000001;

            // trail counter: half steps since run went low, saturating
            if (runb) begin
                s_d.ch[i].trail = 8'h00;
            end else if (tick && s_q.ch[i].trail != 8'hFF) begin
                s_d.ch[i].trail = s_q.ch[i].trail + 8'h01;
            end

            case (s_q.ch[i].st)
                IBB_IDLE: begin
                    s_d.ch[i].pre = 32'h00000000;
                    s_d.ch[i].phase = 12'h000;
                    s_d.ch[i].lit = 1'b0;
                    s_d.ch[i].level = 8'h00;
                    // timer restarts from zero so the first cycle is full length
                    if (ind && runb) begin
                        if (s_q.pat[i][IBB_MODE_BIT]) begin
                            s_d.ch[i].st = IBB_BREATHE; // [R6]
                        end else begin
                            s_d.ch[i].st = IBB_BLINK; // [R6]
                            s_d.ch[i].lit = 1'b1;
                        end
                    end
                end
                IBB_BLINK: begin
                    // each half period lasts rate half steps: 50% duty
                    if (tick) begin
                        if (s_q.ch[i].phase == 12'(rate - 6'h01)) begin // [R2]
                            s_d.ch[i].phase = 12'h000;
                            s_d.ch[i].lit = ~s_q.ch[i].lit;
                            // run clear stops only at a period boundary, never mid-blink
                            if (!s_q.ch[i].lit && !runb &&
                                s_q.ch[i].trail >= {1'b0, tr, 1'b0}) begin // [R4] [R7]
                                s_d.ch[i].st = IBB_IDLE;
                                s_d.ch[i].lit = 1'b0;
                            end
                        end else begin
                            s_d.ch[i].phase = s_q.ch[i].phase + 12'h001;
                        end
                    end
                end
                IBB_BREATHE: begin
                    // ramp up for the first half of the breath, down for the second
                    if (tick) begin
                        if (s_q.ch[i].phase < {1'b0, breath_len[11:1]}) begin // [R13]
                            s_d.ch[i].level = (s_q.ch[i].level > 8'hFF - IBB_RAMP_STEP) ?
                                8'hFF : s_q.ch[i].level + IBB_RAMP_STEP;
                        end else begin
                            s_d.ch[i].level = (s_q.ch[i].level < IBB_RAMP_STEP) ?
                                8'h00 : s_q.ch[i].level - IBB_RAMP_STEP;
                        end
                        if (s_q.ch[i].phase == breath_len - 12'h001) begin // [R7]
                            s_d.ch[i].phase = 12'h000;
                            s_d.ch[i].level = 8'h00;
                            s_d.ch[i].st = (sleep_len == 12'h000) ? IBB_BREATHE : IBB_SLEEP;
                        end else begin
                            s_d.ch[i].phase = s_q.ch[i].phase + 12'h001;
                        end
                    end
                    if (!runb) begin
                        s_d.ch[i].st = IBB_IDLE; // [R8]
                    end
                end
                IBB_SLEEP: begin
                    // dark gap between breaths
                    if (tick) begin
                        if (s_q.ch[i].phase >= sleep_len - 12'h001) begin // [R5]
                            s_d.ch[i].phase = 12'h000;
                            s_d.ch[i].st = IBB_BREATHE;
                        end else begin
                            s_d.ch[i].phase = s_q.ch[i].phase + 12'h001;
                        end
                    end
                    if (!runb) begin
                        s_d.ch[i].st = IBB_IDLE; // [R8]
                    end
                end
                default: begin
                    s_d.ch[i].st = IBB_IDLE;
                end
            endcase

            // leaving indicator function drops the pattern at once
            if (!ind) begin
                s_d.ch[i].st = IBB_IDLE; // [R9]
            end

            // pattern level, then polarity on top of either mode
            if (s_q.ch[i].st == IBB_BLINK) begin
                patv = s_q.ch[i].lit;
            end else if (s_q.ch[i].st == IBB_BREATHE) begin
                patv = (s_q.pwm < s_q.ch[i].level); // [R13]
            end else begin
                patv = 1'b0;
            end

            // pin mux: indicator drives always, general pin follows its direction
            if (ind) begin
                s_d.ch[i].pin_out = patv ^ s_q.pat[i][IBB_POLARITY_BIT]; // [R1] [R14] [R11]
                s_d.ch[i].pin_oe = 1'b1; // [R9]
                s_d.ch[i].gpin = 1'b0; // [R12]
                s_d.gval[i] = 1'b0; // [R12]
            end else begin
                s_d.ch[i].pin_out = gpio_out_data[i]; // [R9]
                s_d.ch[i].pin_oe = gpio_dir[i];
                s_d.ch[i].gpin = s_q.ch[i].pin_sync[1];
                // valid flag is a flop too, so it never leads the data by a cycle
                s_d.gval[i] = 1'b1; // [R12]
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            s_q <= '0;
            s_q.pat <= {IBB_CFG_RESET, IBB_CFG_RESET};
            s_q.run <= {IBB_CFG_RESET, IBB_CFG_RESET};
            s_q.gval <= 2'b11;
            s_q.ch[0].st <= IBB_IDLE;
            s_q.ch[1].st <= IBB_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from flops
    // ------------------------------------------------------------
    assign reg_rdata = s_q.rdata;
    assign pin_out = {s_q.ch[1].pin_out, s_q.ch[0].pin_out};
    assign pin_oe = {s_q.ch[1].pin_oe, s_q.ch[0].pin_oe};
    assign gpio_in_data = {s_q.ch[1].gpin, s_q.ch[0].gpin};
    assign gpio_in_valid = s_q.gval;

endmodule // ibb_indicator_ctrl

`default_nettype wire

/* verilog/ibb_pkg.sv */
// constants, field layout and types for the two-pin indicator blink/breathe block
// assumes a single 100 MHz clock and a byte-wide register port in the same domain
//
// What this block does
// [R1] polarity bit 7 inverts indicator output
// [R2] blink period rate times 50 ms, 50% duty
// [R3] breathe active time rate times 500 ms
// [R4] blink continues for trail time after stop
// [R5] breathe sleeps trail times 500 ms between breaths
// [R6] run bit starts the pattern timer
// [R7] started blink or breath never cut short; the block ends a breath at once on run clear, and either on bit 0 clear
// [R8] breathe stops at once when run clears
// [R9] bit 0 selects general pin or indicator
// [R10] second identical instance at 0x0808 and 0x0809
// [R11] general output data ignored in indicator function
// [R12] general input data invalid in indicator function
// [R13] breathe is a pwm brightness ramp up/down
// [R14] polarity applied after pattern generator, both modes
package ibb_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [15:0] IBB_IND0_PATTERN_OFS = 16'h0806; // indicator0_pattern_cfg
    localparam logic [15:0] IBB_IND0_RUN_OFS = 16'h0807; // indicator0_run_cfg
    localparam logic [15:0] IBB_IND1_PATTERN_OFS = 16'h0808; // indicator1_pattern_cfg
    localparam logic [15:0] IBB_IND1_RUN_OFS = 16'h0809; // indicator1_run_cfg
    localparam logic [7:0] IBB_CFG_RESET = 8'h00; // all config bytes clear at reset

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int IBB_POLARITY_BIT = 7; // pattern cfg: invert output
    localparam int IBB_MODE_BIT = 6; // pattern cfg: 0 blink, 1 breathe
    localparam int IBB_RATE_MSB = 5; // pattern cfg: rate field 5:0
    localparam int IBB_TRAIL_LSB = 2; // run cfg: trail_duration 7:2
    localparam int IBB_RUN_BIT = 1; // run cfg: pattern_run
    localparam int IBB_FUNC_BIT = 0; // run cfg: function select

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int IBB_CLK_KHZ = 100000; // mclk rate
    localparam int IBB_BLINK_STEP_MS = 50; // blink and trail unit
    localparam int IBB_BREATHE_STEP_MS = 500; // breath and sleep unit
    // half a blink step, so a 50% duty period splits into two equal halves
    localparam int IBB_HALF_STEP_CYC = IBB_BLINK_STEP_MS * IBB_CLK_KHZ / 2;
    localparam int IBB_HALVES_PER_BREATHE = IBB_BREATHE_STEP_MS * 2 / IBB_BLINK_STEP_MS;
    localparam logic [7:0] IBB_RAMP_STEP = 8'h1A; // brightness change per half step

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        IBB_IDLE = 4'b0001,
        IBB_BLINK = 4'b0010,
        IBB_BREATHE = 4'b0100,
        IBB_SLEEP = 4'b1000
    } ibb_state_e;

    typedef struct packed {
        ibb_state_e st; // pattern state
        logic [31:0] pre; // half-step prescaler
        logic [11:0] phase; // half steps inside current half period or breath
        logic [7:0] trail; // half steps elapsed since run cleared
        logic lit; // blink level
        logic [7:0] level; // breathe brightness
        logic [1:0] pin_sync; // two-stage input synchroniser
        logic pin_out; // pin drive value
        logic pin_oe; // pin drive enable
        logic gpin; // general input data seen by software
    } ibb_ch_s;
endpackage : ibb_pkg
